// *** hw/cnn_pkg.sv ***
// constants and types shared by the comfort noise block
package cnn_pkg;

    // sample and stream layout
    localparam int SAMPLE_W = 16;
    localparam int WORD_W = 3 * SAMPLE_W + 1; // {processor_active, receive_input, send_out, send_in}
    localparam int FIFO_DEPTH = 16;
    localparam int APB_ADDR_W = 8;

    // register indices as printed, byte address is four times the index
    localparam logic [5:0] IDX_TUNING = 6'h18;
    localparam logic [5:0] IDX_LIMITS = 6'h19;
    localparam logic [5:0] IDX_PCMCFG = 6'h30;
    localparam logic [5:0] IDX_BNSTAT = 6'h24;

    // reset values
    localparam logic [7:0] RST_TUNING = 8'h8a;
    localparam logic [7:0] RST_LIMITS = 8'hee;
    localparam logic [7:0] RST_PCMCFG = 8'h03;

    // field positions
    localparam int OFS_LSB = 0; // noise_level_offset, 4 bits
    localparam int RISE_LSB = 4; // floor_rise_step, 2 bits
    localparam int FALL_LSB = 6; // floor_fall_step, 2 bits
    localparam int SLIM_LSB = 0; // floor_send_level_limit, 4 bits
    localparam int RLIM_LSB = 4; // floor_recv_level_limit, 4 bits
    localparam int NTS_BIT = 0; // noise_type_select
    localparam int CNE_BIT = 1; // constant_noise_enable
    localparam int STAT_SUSP_BIT = 16;

    // arithmetic scaling
    localparam int LIMIT_SHIFT = 11; // limit code to linear level
    localparam int GAIN_FRAC = 6; // gain table is Q6
    localparam logic [15:0] LEVEL_MAX = 16'h7fff;

endpackage : cnn_pkg

// *** hw/cnn_stream_if.sv ***
// valid/ready sample stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface cnn_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cnn_stream_if
`default_nettype wire

// *** hw/cnn_fifo.sv ***
// sample fifo with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none
module cnn_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    cnn_stream_if.snk wr,
    cnn_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic full_q;
    logic empty_q;
    logic push;
    logic pop;

    assign push = wr.valid && !full_q;
    assign pop = !empty_q && rd.ready;
    assign wr.ready = !full_q;
    assign rd.valid = !empty_q;
    assign rd.data = mem[rd_ptr_q];

    // storage has no reset, only the pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= wr.data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // flags come from flops so the producer sees a clean ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
            full_q <= (count_q == (AW + 1)'(DEPTH - 1));
            empty_q <= 1'b0;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
            full_q <= 1'b0;
            empty_q <= (count_q == (AW + 1)'(1));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_FIFO_FULL: assert property (full_q == (count_q == (AW + 1)'(DEPTH)))
        else $error("fifo full flag disagrees with count");
endmodule : cnn_fifo
`default_nettype wire

// *** hw/cnn_top.sv ***
// comfort noise insertion and background noise measurement for the send path
`timescale 1ns/1ps
`default_nettype none
module cnn_top
    import cnn_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // sample stream in
    input wire logic s_valid,
    output logic s_ready,
    input wire logic signed [SAMPLE_W-1:0] s_send_in,
    input wire logic signed [SAMPLE_W-1:0] s_send_out,
    input wire logic signed [SAMPLE_W-1:0] s_receive_input,
    input wire logic s_nonlinear_processor,
    // sample stream out
    output logic m_valid,
    input wire logic m_ready,
    output logic signed [SAMPLE_W-1:0] m_sample,
    // status
    output logic [SAMPLE_W-1:0] background_noise_level,
    output logic background_noise_suspended
);

    // absolute value, saturating the most negative code
    function automatic logic [15:0] mag16(input logic [15:0] x);
        logic [15:0] n;
        n = 16'h0000 - x;
        if (!x[15]) begin
            return x;
        end else if (x == 16'h8000) begin
            return LEVEL_MAX;
        end else begin
            return n;
        end
    endfunction

    // offset code to Q6 gain in 1.5 dB steps, code 4 is unity
    function automatic logic [9:0] gain_of(input logic [3:0] code);
        case (code)
            4'h0: return 10'h020;
            4'h1: return 10'h026;
            4'h2: return 10'h02d;
            4'h3: return 10'h036;
            4'h4: return 10'h040;
            4'h5: return 10'h04c;
            4'h6: return 10'h05a;
            4'h7: return 10'h06b;
            4'h8: return 10'h080;
            4'h9: return 10'h098;
            4'ha: return 10'h0b4;
            4'hb: return 10'h0d6;
            4'hc: return 10'h0ff;
            4'hd: return 10'h12f;
            4'he: return 10'h168;
            default: return 10'h1ab;
        endcase
    endfunction

    // register index of an apb byte address
    function automatic logic [5:0] index_of(input logic [APB_ADDR_W-1:0] a);
        return a[7:2];
    endfunction

    // ---------------- apb slave ----------------
    logic [7:0] tuning_q;
    logic [7:0] limits_q;
    logic [7:0] pcmcfg_q;
    logic apb_setup;
    logic apb_write;
    logic mapped;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign mapped = (index_of(paddr) == IDX_TUNING) || (index_of(paddr) == IDX_LIMITS)
        || (index_of(paddr) == IDX_PCMCFG) || (index_of(paddr) == IDX_BNSTAT);

    // zero wait state: the answer is prepared during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && (!mapped
                || (pwrite && index_of(paddr) == IDX_BNSTAT));
            prdata <= 32'h0000_0000;
            if (apb_setup && !pwrite && index_of(paddr) == IDX_BNSTAT) begin
                prdata <= {15'h0000, background_noise_suspended, background_noise_level};
            end
        end
    end

    // configuration is write only and reads back as zero; low byte lane only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tuning_q <= RST_TUNING;
            limits_q <= RST_LIMITS;
            pcmcfg_q <= RST_PCMCFG;
        end else if (apb_write && pstrb[0]) begin
            if (index_of(paddr) == IDX_TUNING) begin
                tuning_q <= pwdata[7:0];
            end
            if (index_of(paddr) == IDX_LIMITS) begin
                limits_q <= pwdata[7:0];
            end
            if (index_of(paddr) == IDX_PCMCFG) begin
                pcmcfg_q <= pwdata[7:0];
            end
        end
    end

    logic [3:0] noise_level_offset;
    logic [1:0] floor_rise_step;
    logic [1:0] floor_fall_step;
    logic [3:0] floor_send_level_limit;
    logic [3:0] floor_recv_level_limit;
    logic noise_type_select;
    logic constant_noise_enable;

    assign noise_level_offset = tuning_q[OFS_LSB +: 4];
    assign floor_rise_step = tuning_q[RISE_LSB +: 2];
    assign floor_fall_step = tuning_q[FALL_LSB +: 2];
    assign floor_send_level_limit = limits_q[SLIM_LSB +: 4];
    assign floor_recv_level_limit = limits_q[RLIM_LSB +: 4];
    assign noise_type_select = pcmcfg_q[NTS_BIT];
    assign constant_noise_enable = pcmcfg_q[CNE_BIT];

    // ---------------- input fifo ----------------
    cnn_stream_if #(.W(WORD_W)) in_if ();
    cnn_stream_if #(.W(WORD_W)) out_if ();

    assign in_if.valid = s_valid;
    assign in_if.data = {s_nonlinear_processor, s_receive_input, s_send_out, s_send_in};
    assign s_ready = in_if.ready;

    cnn_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .wr(in_if),
        .rd(out_if)
    );

    // a stalled consumer stops the pop, so back-pressure reaches s_ready
    logic take;
    assign take = out_if.valid && (!m_valid || m_ready);
    assign out_if.ready = !m_valid || m_ready;

    logic [15:0] smp [3];
    logic proc_on;
    assign smp[0] = out_if.data[0 +: SAMPLE_W];
    assign smp[1] = out_if.data[SAMPLE_W +: SAMPLE_W];
    assign smp[2] = out_if.data[2 * SAMPLE_W +: SAMPLE_W];
    assign proc_on = out_if.data[WORD_W - 1];

    // ---------------- level meters: send in, send out, receive input ----------------
    logic [15:0] lvl_q [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_meter
            logic [16:0] diff;
            assign diff = {1'b0, mag16(smp[g])} - {1'b0, lvl_q[g]};
            // first order smoother, one eighth of the error per sample
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lvl_q[g] <= 16'h0000;
                end else if (take) begin
                    lvl_q[g] <= lvl_q[g] + {{3{diff[16]}}, diff[15:3]};
                end
            end
        end
    endgenerate

    logic [15:0] send_lvl;
    logic send_over;
    logic recv_over;
    logic suspend;
    assign send_lvl = (lvl_q[0] > lvl_q[1]) ? lvl_q[0] : lvl_q[1];
    assign send_over = send_lvl > (16'(floor_send_level_limit) << LIMIT_SHIFT);
    assign recv_over = lvl_q[2] > (16'(floor_recv_level_limit) << LIMIT_SHIFT);
    assign suspend = send_over || recv_over;

    // ---------------- background noise floor ----------------
    logic [15:0] floor_q;
    logic [15:0] rise_amt;
    logic [15:0] fall_amt;
    logic [15:0] si_mag;
    assign rise_amt = 16'h0001 << floor_rise_step;
    assign fall_amt = 16'h0001 << floor_fall_step;
    assign si_mag = mag16(smp[0]);

    // step up or down toward the send input; frozen while suspended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            floor_q <= 16'h0000;
        end else if (take && !suspend) begin
            if (si_mag > floor_q) begin
                floor_q <= (floor_q > LEVEL_MAX - rise_amt) ? LEVEL_MAX : floor_q + rise_amt;
            end else if (si_mag < floor_q) begin
                floor_q <= (floor_q < fall_amt) ? 16'h0000 : floor_q - fall_amt;
            end
        end
    end

    // status outputs registered so they stay glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            background_noise_level <= 16'h0000;
            background_noise_suspended <= 1'b0;
        end else begin
            background_noise_level <= floor_q;
            background_noise_suspended <= suspend;
        end
    end

    // ---------------- comfort noise level ----------------
    logic [25:0] scaled;
    logic [15:0] cn_level;
    assign scaled = 26'(floor_q) * 26'(gain_of(noise_level_offset));
    assign cn_level = (scaled[25:GAIN_FRAC] > 20'(LEVEL_MAX)) ? LEVEL_MAX
        : scaled[GAIN_FRAC +: 16];

    // noise source; the band-limited sign is held two samples, halving its bandwidth
    logic [15:0] lfsr_q;
    logic half_q;
    logic sign_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= 16'h9b1d;
            half_q <= 1'b0;
            sign_q <= 1'b0;
        end else if (take) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            half_q <= !half_q;
            if (!half_q) begin
                sign_q <= lfsr_q[0];
            end
        end
    end

    // ---------------- send output selection ----------------
    logic [15:0] so_mag;
    logic [15:0] repl;
    assign so_mag = mag16(smp[1]);

    always_comb begin
        repl = 16'h0000;
        if (noise_type_select) begin
            if (constant_noise_enable) begin
                repl = sign_q ? 16'h0000 - cn_level : cn_level;
            end
        end else if (so_mag > cn_level) begin
            repl = smp[1][15] ? 16'h0000 - cn_level : cn_level;
        end else begin
            repl = smp[1];
        end
    end

    // output stage; the level used is the held one while suspended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_valid <= 1'b0;
            m_sample <= 16'sh0000;
        end else if (take) begin
            m_valid <= 1'b1;
            m_sample <= proc_on ? repl : smp[1];
        end else if (m_ready) begin
            m_valid <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take_active;
        take && proc_on;
    endsequence

    sequence s_take_bypass;
        take && !proc_on;
    endsequence

    AST_PASS_THROUGH: assert property (s_take_bypass |=> m_sample == $past(smp[1]))
        else $error("send output altered while processor inactive");
    AST_DEAD_LINE: assert property (
        s_take_active and (noise_type_select && !constant_noise_enable) |=> m_sample == 16'sh0000)
        else $error("dead line mode did not give zero");
    AST_CONST_AMP: assert property (
        s_take_active and (noise_type_select && constant_noise_enable)
        |=> mag16(m_sample) == $past(cn_level))
        else $error("constant noise amplitude wrong");
    AST_SUBJ_LIMIT: assert property (s_take_active and !noise_type_select
        |=> mag16(m_sample) <= $past(cn_level) && m_valid)
        else $error("subjective output exceeds level");
    AST_NOISE_TYPE: assert property (s_take_active and !noise_type_select
        and (so_mag <= cn_level) |=> m_sample == $past(smp[1]))
        else $error("subjective mode inserted noise");
    AST_HOLD_FLOOR: assert property (take && suspend |=> $stable(floor_q))
        else $error("floor moved while suspended");
    // the limits are checked at the floor and the status flop, not at suspend itself
    AST_SEND_LIMIT: assert property (take
        && send_lvl > (16'(floor_send_level_limit) << LIMIT_SHIFT)
        |=> $stable(floor_q) && background_noise_suspended)
        else $error("send level over limit did not suspend");
    AST_RECV_LIMIT: assert property (take
        && lvl_q[2] > (16'(floor_recv_level_limit) << LIMIT_SHIFT)
        |=> $stable(floor_q) && background_noise_suspended)
        else $error("receive level over limit did not suspend");
    AST_RISE: assert property (take && !suspend && si_mag > floor_q
        && floor_q <= LEVEL_MAX - rise_amt |=> floor_q == $past(floor_q) + $past(rise_amt))
        else $error("floor rise step wrong");
    AST_OFFSET_UP: assert property ($stable(floor_q) && $past(noise_level_offset)
        < noise_level_offset |-> cn_level >= $past(cn_level))
        else $error("raising offset lowered noise level");
    AST_STALL: assert property (m_valid && !m_ready |=> m_valid && $stable(m_sample))
        else $error("output dropped under stall");

endmodule : cnn_top
`default_nettype wire

// *** testbench/cnn_pcm_model.sv ***
// far-side highway model: feeds sample words and takes the send output
`timescale 1ns/1ps
`default_nettype none
module cnn_pcm_model
    import cnn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic s_ready,
    input wire logic m_valid,
    input wire logic signed [SAMPLE_W-1:0] m_sample,
    output logic s_valid,
    output logic [WORD_W-1:0] word,
    output logic m_ready
);
    logic [WORD_W-1:0] txq[$];
    logic signed [SAMPLE_W-1:0] rxq[$];
    int n_acc = 0;
    int ph = 0;
    bit hold = 1'b0;
    bit slow = 1'b0;
    // a word leaves the queue only on an accepted edge; idle words are scrambled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_valid <= 1'b0;
            word <= '0;
            m_ready <= 1'b0;
        end else begin
            if (s_valid && s_ready) begin
                void'(txq.pop_front());
                n_acc++;
            end
            if (m_valid && m_ready) rxq.push_back(m_sample);
            ph++;
            s_valid <= (txq.size() != 0);
            word <= (txq.size() != 0) ? txq[0] : ~word;
            // slow mode takes one output in three, hold stalls the sink fully
            m_ready <= !hold && (!slow || ph % 3 == 0);
        end
    end
endmodule // cnn_pcm_model
`default_nettype wire

// *** testbench/comfort_noise_nlp_config_tb.sv ***
// self-checking bench for the comfort noise block
`timescale 1ns/1ps
`default_nettype none
module comfort_noise_nlp_config_tb
    import cnn_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err, s_valid, s_ready, m_valid, m_ready, floor_susp;
    logic [WORD_W-1:0] word;
    logic signed [SAMPLE_W-1:0] m_sample;
    logic [SAMPLE_W-1:0] floor_lvl;
    logic signed [SAMPLE_W-1:0] expq[$];
    bit magq[$];
    int n_mismatch = 0, num_checks = 0, seed = 41930;
    // code 2 is subjective with the unused enable bit set
    int cfgs[4] = '{3, 1, 0, 2};
    // comfort level for a floor of 64 equals the gain entry itself
    int gain[16] = '{16'h20, 16'h26, 16'h2d, 16'h36, 16'h40, 16'h4c, 16'h5a, 16'h6b,
                     16'h80, 16'h98, 16'hb4, 16'hd6, 16'hff, 16'h12f, 16'h168, 16'h1ab};

    cnn_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
        .s_send_in(word[15:0]), .s_send_out(word[31:16]), .s_receive_input(word[47:32]),
        .s_nonlinear_processor(word[48]), .m_valid(m_valid), .m_ready(m_ready),
        .m_sample(m_sample), .background_noise_level(floor_lvl),
        .background_noise_suspended(floor_susp));
    cnn_pcm_model pcm (.pclk(pclk), .presetn(presetn), .s_ready(s_ready), .m_valid(m_valid),
        .m_sample(m_sample), .s_valid(s_valid), .word(word), .m_ready(m_ready));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // one apb transfer, entered just after an edge; an idle cycle follows
    task automatic apb(input bit wr, input logic [5:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count is assumed; only the watchdog ends a lost answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic int expect_out(input int cfg, input int so, input bit act, input int l);
        if (!act) return so;
        if (cfg == 3) return l;
        if (cfg == 1) return 0;
        return so > l ? l : (so < -l ? -l : so);
    endfunction

    // queue n words; l < 0 keeps the processor flag off while the floor moves
    task automatic feed(input int n, input int mag, input int sof, input int rx, input int cfg,
                        input int l);
        int so;
        int si;
        bit act;
        repeat (n) begin
            so = (sof != 0) ? sof : $random(seed) % 1000;
            si = ($random(seed) % 2 != 0) ? mag : -mag;
            act = (l >= 0) && ($random(seed) % 2 != 0);
            pcm.txq.push_back({act, 16'(rx), 16'(so), 16'(si)});
            expq.push_back(16'(expect_out(cfg, so, act, l)));
            magq.push_back(act && cfg == 3);
        end
    endtask

    task automatic drain();
        int k;
        logic signed [SAMPLE_W-1:0] g;
        k = 0;
        while (pcm.rxq.size() < expq.size() && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        chk("output count", expq.size(), pcm.rxq.size());
        while (expq.size() != 0 && pcm.rxq.size() != 0) begin
            g = pcm.rxq.pop_front();
            if (magq.pop_front() && g < 0) g = -g;
            chk("send output", expq.pop_front(), g);
        end
        expq.delete();
        magq.delete();
        pcm.rxq.delete();
    endtask

    task automatic status(input int f, input bit s);
        apb(0, IDX_BNSTAT, 8'h00);
        chk("status reg", {15'h0, s, 16'(f)}, rd);
        chk("floor port", f, floor_lvl);
        chk("suspend port", s, floor_susp);
    endtask

    initial begin
        do_reset();
        apb(0, IDX_TUNING, 8'h00);
        chk("write-only read", 32'h0, rd);
        chk("tuning err", 0, err);
        apb(0, IDX_BNSTAT, 8'h00);
        chk("status at reset", 32'h0, rd);
        apb(0, 6'h00, 8'h00);
        chk("unmapped err", 1, err);
        apb(1, IDX_BNSTAT, 8'hff);
        chk("status write err", 1, err);
        // sink stalled: the fifo plus the output register hold the words, then refuse
        pcm.hold = 1'b1;
        feed(40, 64, 0, 100, 3, -1);
        repeat (60) @(posedge pclk);
        chk("words taken while stalled", FIFO_DEPTH + 1, pcm.n_acc);
        chk("ready while full", 0, s_ready);
        pcm.hold = 1'b0;
        pcm.slow = 1'b1;
        drain();
        pcm.slow = 1'b0;
        status(40, 0);
        // rise by 4 up to the input magnitude, fall by 8, rise by 8 back
        apb(1, IDX_TUNING, 8'h22);
        feed(8, 64, 0, 100, 3, -1);
        drain();
        status(64, 0);
        apb(1, IDX_TUNING, 8'hc0);
        feed(3, 32, 0, 100, 3, -1);
        drain();
        status(40, 0);
        apb(1, IDX_TUNING, 8'h30);
        feed(3, 64, 0, 100, 3, -1);
        drain();
        status(64, 0);
        // every noise style at every offset; codes 2 and 8 are among them
        foreach (cfgs[c]) begin
            apb(1, IDX_PCMCFG, 8'(cfgs[c]));
            for (int o = 0; o < 16; o++) begin
                apb(1, IDX_TUNING, 8'(o));
                feed(4, 64, 0, 100, cfgs[c], gain[o]);
                drain();
            end
        end
        // loud send output halts the floor after the first sample
        do_reset();
        apb(1, IDX_LIMITS, 8'he1);
        feed(20, 64, 30000, 0, 3, -1);
        drain();
        status(1, 1);
        // loud receive input does the same, held floor drives the noise
        do_reset();
        apb(1, IDX_LIMITS, 8'h1e);
        feed(20, 64, 0, 30000, 3, -1);
        drain();
        status(1, 1);
        apb(1, IDX_TUNING, 8'h04);
        feed(6, 64, 0, 30000, 3, 1);
        drain();
        give_verdict();
    end

    // the whole run needs about a thousand cycles
    initial begin
        #300000;
        n_mismatch++;
        give_verdict();
    end
endmodule // comfort_noise_nlp_config_tb
`default_nettype wire
